// *** design/hrm_map.sv ***
// Host register map with data and status FIFO ports.
// Assumes a synchronous host strobe interface on clk; FIFOs live outside.
`timescale 1ns/1ps
`include "hrm_regs.svh"
module hrm_map #(
  parameter logic [15:0] PART_ID  = 16'h00a5, // Arbitrary value
  parameter logic [15:0] REVISION = 16'h0002  // Arbitrary value
) (
  input  wire logic              clk,
  input  wire logic              reset_n,          // System / power-on reset
  input  wire logic              sw_reset_n,       // Software reset, active low
  // Host strobe port
  input  wire logic              host_cs,
  input  wire logic              host_wr,
  input  wire logic              host_rd,
  input  wire hrm_pkg::hrm_addr_t host_addr,
  input  wire hrm_pkg::hrm_word_t host_wdata,
  output logic                   host_rvalid,
  output hrm_pkg::hrm_word_t     host_rdata,
  // Receive data FIFO (drain side)
  input  wire logic              rxd_valid,
  input  wire hrm_pkg::hrm_word_t rxd_data,
  output logic                   rxd_pop,
  // Receive status FIFO
  input  wire logic              rxs_valid,
  input  wire hrm_pkg::hrm_word_t rxs_data,
  output logic                   rxs_pop,
  // Transmit status FIFO
  input  wire logic              txs_valid,
  input  wire hrm_pkg::hrm_word_t txs_data,
  output logic                   txs_pop,
  // Transmit data out, through two-entry buffer
  output logic                   txd_valid,
  output hrm_pkg::hrm_word_t     txd_data,
  input  wire logic              txd_ready,
  output logic                   txd_host_ready,   // Host may write transmit data
  // Block state in, configuration out
  input  wire hrm_pkg::hrm_word_t int_events,      // Hardware sets interrupt status
  input  wire hrm_pkg::hrm_word_t rx_fifo_level,
  input  wire hrm_pkg::hrm_word_t tx_fifo_level,
  input  wire hrm_pkg::hrm_word_t timer_count,
  input  wire logic              rx_drop_inc,
  output logic [3:0]             fifo_size_sel,    // Sizes of data and status FIFOs
  output logic                   soft_reset_req,
  output hrm_pkg::hrm_word_t     irq_pin_config,
  output hrm_pkg::hrm_word_t     interrupt_enable,
  output hrm_pkg::hrm_word_t     receive_config,
  output hrm_pkg::hrm_word_t     transmit_config
);

  // Clock
  //   Single clock domain, clk
  //   No clock enable
  // Reset scheme
  //   reset_n: system and power-on
  //   sw_reset_n: software, spares
  //   the exempt pin config bits
  //   Both sampled on clk
  // Host access
  //   One strobe cycle per access
  //   No wait states
  //   Writes land on the strobe edge
  //   Read answer one cycle later
  // FIFO ports
  //   Show-ahead heads with valid
  //   Pops only when a head is valid
  // Config outputs straight from flops

  // Access qualifiers
  logic rd_acc;
  logic wr_acc;
  logic rst_all;                                 // Any reset: system, soft or power-on
  logic in_rxd;
  logic in_txd;
  assign rd_acc  = host_cs && host_rd;
  assign wr_acc  = host_cs && host_wr;
  assign rst_all = !reset_n || !sw_reset_n;
  assign in_rxd  = host_addr <= `HRM_RX_DATA_HI;
  assign in_txd  = host_addr >= `HRM_TX_DATA_LO && host_addr <= `HRM_TX_DATA_HI;

  // Identity, endian check and FIFO
  // levels are muxed onto the read
  // path and cost no flops
  // Stored registers
  hrm_pkg::hrm_word_t interrupt_status;
  hrm_pkg::hrm_word_t fifo_level_irq;
  hrm_pkg::hrm_word_t hardware_config;
  hrm_pkg::hrm_word_t receive_path_control;
  hrm_pkg::hrm_word_t power_mgmt_control;
  hrm_pkg::hrm_word_t gp_io_config;
  hrm_pkg::hrm_word_t gp_timer_config;
  hrm_pkg::hrm_word_t half_word_swap;
  hrm_pkg::hrm_word_t free_running_counter;
  hrm_pkg::hrm_word_t dropped_frame_count;
  hrm_pkg::hrm_word_t mac_indirect_command;
  hrm_pkg::hrm_word_t mac_indirect_data;
  hrm_pkg::hrm_word_t auto_flow_control;
  hrm_pkg::hrm_word_t eeprom_command;
  hrm_pkg::hrm_word_t eeprom_data;

  // Exact compare: a misaligned
  // offset touches no register
  // Write strobe per address
  function automatic logic wr_hit(input hrm_pkg::hrm_addr_t a);
    wr_hit = wr_acc && host_addr == a;
  endfunction

  // System reset, then soft reset,
  // then host write; the self-clear
  // bit lasts one cycle after a write
  // Interrupt pin config: exempt bits reset only by system reset
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      irq_pin_config <= `HRM_RST_ZERO;
    else if (!sw_reset_n)
      irq_pin_config <= irq_pin_config & `HRM_IRQ_EXEMPT;
    else if (wr_hit(`HRM_IRQ_CFG))
      irq_pin_config <= host_wdata & `HRM_IRQ_WMASK;
    else
      irq_pin_config[`HRM_IRQ_SC_BIT] <= 1'b0;                      // Self clearing
  end

  // Set beats clear in one cycle, so
  // an event during an acknowledge
  // is not lost; a zero bit keeps
  // Interrupt status: event set wins over write-one clear
  always_ff @(posedge clk)
  begin
    if (rst_all)
      interrupt_status <= `HRM_RST_ZERO;
    else if (wr_hit(`HRM_INTERRUPT_STATUS))
      interrupt_status <= (interrupt_status & ~host_wdata) | int_events;
    else
      interrupt_status <= interrupt_status | int_events;
  end

  // All 32 bits stored as written;
  // the host keeps reserved fields
  // zero, fields act outside
  // Plain read/write control registers
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      interrupt_enable     <= `HRM_RST_ZERO;
      fifo_level_irq       <= `HRM_RST_FIFO_INT;
      receive_config       <= `HRM_RST_ZERO;
      transmit_config      <= `HRM_RST_ZERO;
      receive_path_control <= `HRM_RST_ZERO;
      power_mgmt_control   <= `HRM_RST_ZERO;
      gp_io_config         <= `HRM_RST_ZERO;
      gp_timer_config      <= `HRM_RST_GPT;
      half_word_swap       <= `HRM_RST_ZERO;
      mac_indirect_command <= `HRM_RST_ZERO;
      mac_indirect_data    <= `HRM_RST_ZERO;
      auto_flow_control    <= `HRM_RST_ZERO;
      eeprom_command       <= `HRM_RST_ZERO;
      eeprom_data          <= `HRM_RST_ZERO;
    end
    else
    begin
      if (wr_hit(`HRM_INT_EN))    interrupt_enable     <= host_wdata;
      if (wr_hit(`HRM_FIFO_INT))  fifo_level_irq       <= host_wdata;
      if (wr_hit(`HRM_RX_CFG))    receive_config       <= host_wdata;
      if (wr_hit(`HRM_TX_CFG))    transmit_config      <= host_wdata;
      if (wr_hit(`HRM_RECEIVE_PATH_CONTROL)) receive_path_control <= host_wdata;
      if (wr_hit(`HRM_POWER_MGMT_CONTROL))  power_mgmt_control   <= host_wdata;
      if (wr_hit(`HRM_GPIO_CFG))  gp_io_config         <= host_wdata;
      if (wr_hit(`HRM_GP_TIMER_CONFIG))   gp_timer_config      <= host_wdata;
      if (wr_hit(`HRM_WORD_SWAP)) half_word_swap       <= host_wdata;
      if (wr_hit(`HRM_MAC_CMD))   mac_indirect_command <= host_wdata;
      if (wr_hit(`HRM_MAC_DATA))  mac_indirect_data    <= host_wdata;
      if (wr_hit(`HRM_AUTO_FLOW_CONTROL))   auto_flow_control    <= host_wdata;
      if (wr_hit(`HRM_EEPROM_COMMAND))   eeprom_command       <= host_wdata;
      if (wr_hit(`HRM_EEPROM_DATA))  eeprom_data          <= host_wdata;
    end
  end

  // Only the size field and the soft
  // reset request are writable; the
  // request is a one-cycle pulse for
  // the reset controller outside
  // Sizes feed the FIFO split outside
  // Hardware config: size field writable, soft reset bit self clears
  always_ff @(posedge clk)
  begin
    if (rst_all)
      hardware_config <= `HRM_RST_HARDWARE_CONFIG;
    else if (wr_hit(`HRM_HARDWARE_CONFIG))
      hardware_config <= (host_wdata & `HRM_HW_WMASK)
                       | {31'h0000_0000, host_wdata[`HRM_HW_SRST_BIT]};
    else
      hardware_config[`HRM_HW_SRST_BIT] <= 1'b0;
  end
  assign fifo_size_sel  = hardware_config[19:16];
  assign soft_reset_req = hardware_config[`HRM_HW_SRST_BIT];

  // Free running counter: system reset only
  // Wraps silently; soft reset keeps it
  always_ff @(posedge clk)
  begin
    if (!reset_n)
      free_running_counter <= `HRM_RST_ZERO;
    else
      free_running_counter <= free_running_counter + 32'h0000_0001;
  end

  // The read mux takes the old count
  // in the clearing cycle, so no drop
  // is lost or counted twice
  // Dropped frame counter clears on read; a drop in the read cycle counts
  always_ff @(posedge clk)
  begin
    if (rst_all)
      dropped_frame_count <= `HRM_RST_ZERO;
    else if (rd_acc && host_addr == `HRM_RX_DROP)
      dropped_frame_count <= {31'h0000_0000, rx_drop_inc};
    else if (rx_drop_inc)
      dropped_frame_count <= dropped_frame_count + 32'h0000_0001;
  end

  // Combinational pops advance the
  // FIFO on the edge that captures
  // the answer; next read sees next
  // FIFO pops: only when a word is present, so empty reads keep pointers
  assign rxd_pop = rd_acc && in_rxd && rxd_valid;
  assign rxs_pop = rd_acc && host_addr == `HRM_RX_STS_POP && rxs_valid;
  assign txs_pop = rd_acc && host_addr == `HRM_TX_STS_POP && txs_valid;

  // Read decode
  //   00h-1Ch receive data aliases
  //   20h-3Ch transmit aliases, zero
  //   40h-4Ch status pop and peek
  //   50h-B4h control and status
  //   Else reserved, reads zero
  //   Unmatched codes: default branch
  // Read data mux
  hrm_pkg::hrm_word_t next_rdata;
  always_comb
  begin
    next_rdata = `HRM_RSVD_READ;
    if (in_rxd)
      next_rdata = rxd_valid ? rxd_data : `HRM_RST_ZERO;
    else if (in_txd)
      next_rdata = `HRM_RST_ZERO;
    else
    begin
      unique case (host_addr)
        `HRM_RX_STS_POP,
        `HRM_RX_STS_PEEK: next_rdata = rxs_valid ? rxs_data : `HRM_RST_ZERO;
        `HRM_TX_STS_POP,
        `HRM_TX_STS_PEEK: next_rdata = txs_valid ? txs_data : `HRM_RST_ZERO;
        `HRM_ID:          next_rdata = {PART_ID, REVISION};
        `HRM_IRQ_CFG:     next_rdata = irq_pin_config;
        `HRM_INTERRUPT_STATUS:     next_rdata = interrupt_status;
        `HRM_INT_EN:      next_rdata = interrupt_enable;
        `HRM_ENDIAN:      next_rdata = `HRM_RST_ENDIAN;
        `HRM_FIFO_INT:    next_rdata = fifo_level_irq;
        `HRM_RX_CFG:      next_rdata = receive_config;
        `HRM_TX_CFG:      next_rdata = transmit_config;
        `HRM_HARDWARE_CONFIG:      next_rdata = hardware_config;
        `HRM_RECEIVE_PATH_CONTROL:   next_rdata = receive_path_control;
        `HRM_RECEIVE_FIFO_INFO: next_rdata = rx_fifo_level;
        `HRM_TRANSMIT_FIFO_INFO: next_rdata = tx_fifo_level;
        `HRM_POWER_MGMT_CONTROL:    next_rdata = power_mgmt_control;
        `HRM_GPIO_CFG:    next_rdata = gp_io_config;
        `HRM_GP_TIMER_CONFIG:     next_rdata = gp_timer_config;
        `HRM_GP_TIMER_COUNT:     next_rdata = timer_count;
        `HRM_WORD_SWAP:   next_rdata = half_word_swap;
        `HRM_FREE_RUN:    next_rdata = free_running_counter;
        `HRM_RX_DROP:     next_rdata = dropped_frame_count;
        `HRM_MAC_CMD:     next_rdata = mac_indirect_command;
        `HRM_MAC_DATA:    next_rdata = mac_indirect_data;
        `HRM_AUTO_FLOW_CONTROL:     next_rdata = auto_flow_control;
        `HRM_EEPROM_COMMAND:     next_rdata = eeprom_command;
        `HRM_EEPROM_DATA:    next_rdata = eeprom_data;
        default:          next_rdata = `HRM_RSVD_READ;              // Reserved, 60h, 94h, B8h+
      endcase
    end
  end

  // Data holds until the next read;
  // host_rvalid marks the first cycle
  // Registered read answer, one cycle after the strobe
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      host_rvalid <= 1'b0;
      host_rdata  <= `HRM_RST_ZERO;
    end
    else
    begin
      host_rvalid <= rd_acc;
      if (rd_acc)
        host_rdata <= next_rdata;
    end
  end

  // Transmit buffer
  //   Two entries ride out a stall
  //   Full buffer drops the write, so
  //   the host checks space first
  //   Push with drain keeps the count
  //   Data from flops, not the bus
  //   Any alias, one stream
  // Two-entry transmit data buffer; a full buffer drops host_ready
  hrm_pkg::hrm_word_t buf_q [2];
  logic               wr_ptr;
  logic               rd_ptr;
  logic [1:0]         count;
  logic               push;
  logic               drain;
  assign txd_host_ready = count != 2'h2;
  assign push  = wr_acc && in_txd && txd_host_ready;
  assign drain = txd_valid && txd_ready;
  assign txd_valid = count != 2'h0;
  assign txd_data  = buf_q[rd_ptr];

  // No reset: read only while valid
  // Buffer storage; any alias lands in the entry at wr_ptr
  always_ff @(posedge clk)
  begin
    if (push)
      buf_q[wr_ptr] <= host_wdata;
  end

  // One-bit pointers; count tells full
  // Buffer pointers and occupancy
  always_ff @(posedge clk)
  begin
    if (rst_all)
    begin
      wr_ptr <= 1'b0;
      rd_ptr <= 1'b0;
      count  <= 2'h0;
    end
    else
    begin
      if (push)
        wr_ptr <= !wr_ptr;
      if (drain)
        rd_ptr <= !rd_ptr;
      count <= count + {1'b0, push} - {1'b0, drain};
    end
  end

  // Limitations
  //   32-bit host words only
  //   No 16-bit mode aliases

endmodule // hrm_map

// *** pkg/hrm_regs.svh ***
// Register offsets, reset values and field positions for the host register map.
// Assumes byte addresses on the host bus; one 32-bit word per register.
`ifndef HRM_REGS_SVH
`define HRM_REGS_SVH
`define HRM_RX_DATA_LO    8'h00
`define HRM_RX_DATA_HI    8'h1c
`define HRM_TX_DATA_LO    8'h20
`define HRM_TX_DATA_HI    8'h3c
`define HRM_RX_STS_POP    8'h40
`define HRM_RX_STS_PEEK   8'h44
`define HRM_TX_STS_POP    8'h48
`define HRM_TX_STS_PEEK   8'h4c
`define HRM_CSR_LO        8'h50
`define HRM_CSR_HI        8'hb4
`define HRM_ID            8'h50
`define HRM_IRQ_CFG       8'h54
`define HRM_INTERRUPT_STATUS       8'h58
`define HRM_INT_EN        8'h5c
`define HRM_RSVD_60       8'h60
`define HRM_ENDIAN        8'h64
`define HRM_FIFO_INT      8'h68
`define HRM_RX_CFG        8'h6c
`define HRM_TX_CFG        8'h70
`define HRM_HARDWARE_CONFIG        8'h74
`define HRM_RECEIVE_PATH_CONTROL     8'h78
`define HRM_RECEIVE_FIFO_INFO   8'h7c
`define HRM_TRANSMIT_FIFO_INFO   8'h80
`define HRM_POWER_MGMT_CONTROL      8'h84
`define HRM_GPIO_CFG      8'h88
`define HRM_GP_TIMER_CONFIG       8'h8c
`define HRM_GP_TIMER_COUNT       8'h90
`define HRM_RSVD_94       8'h94
`define HRM_WORD_SWAP     8'h98
`define HRM_FREE_RUN      8'h9c
`define HRM_RX_DROP       8'ha0
`define HRM_MAC_CMD       8'ha4
`define HRM_MAC_DATA      8'ha8
`define HRM_AUTO_FLOW_CONTROL       8'hac
`define HRM_EEPROM_COMMAND       8'hb0
`define HRM_EEPROM_DATA      8'hb4
`define HRM_RST_ZERO      32'h0000_0000
`define HRM_RST_ENDIAN    32'h8765_4321
`define HRM_RST_FIFO_INT  32'h4800_0000
`define HRM_RST_HARDWARE_CONFIG    32'h0005_0000
`define HRM_RST_TX_INF    32'h0000_1200
`define HRM_RST_GPT       32'h0000_ffff
`define HRM_RSVD_READ     32'h0000_0000
// Soft-reset-exempt bits of the interrupt pin configuration (polarity, buffer type)
`define HRM_IRQ_EXEMPT    32'h0000_0011
// Writable bits of the interrupt pin configuration
`define HRM_IRQ_WMASK     32'hff00_4111
// Write-one self-clearing bit (deassertion interval clear)
`define HRM_IRQ_SC_BIT    14
// Hardware config: soft reset request (self clearing), sizes field 19:16
`define HRM_HW_SRST_BIT   0
`define HRM_HW_WMASK      32'h000f_0000
`endif

// *** pkg/hrm_pkg.sv ***
// Types shared by the host register map.
// Assumes the constants header supplies all numbers.
package hrm_pkg;
  typedef logic [31:0] hrm_word_t;   // One host data word
  typedef logic [7:0]  hrm_addr_t;   // Byte offset within the map
  typedef enum logic [1:0]
  {
    HRM_IDLE = 2'b00,
    HRM_READ = 2'b01,
    HRM_HOLD = 2'b10
  } hrm_rd_e;
endpackage

// *** tb/hrm_map_monitor.sv ***
// Port checker for the host register map.
// Assumes a bind onto hrm_map; one clock, both resets synchronous.
`timescale 1ns/1ps
module hrm_map_monitor (
  input wire logic               clk,
  input wire logic               reset_n,
  input wire logic               sw_reset_n,
  input wire logic               host_cs,
  input wire logic               host_wr,
  input wire logic               host_rd,
  input wire hrm_pkg::hrm_addr_t host_addr,
  input wire hrm_pkg::hrm_word_t host_wdata,
  input wire logic               host_rvalid,
  input wire hrm_pkg::hrm_word_t host_rdata,
  input wire logic               rxd_valid,
  input wire logic               rxd_pop,
  input wire logic               rxs_valid,
  input wire hrm_pkg::hrm_word_t rxs_data,
  input wire logic               rxs_pop,
  input wire logic               txs_valid,
  input wire logic               txs_pop,
  input wire logic               txd_valid,
  input wire hrm_pkg::hrm_word_t txd_data,
  input wire logic               txd_ready,
  input wire logic               txd_host_ready
);
  // Either reset clears the read path, so both silence checks
  default clocking mon_cb @(posedge clk);
  endclocking
  default disable iff (!reset_n || !sw_reset_n);
  wire logic rd_take = host_cs && host_rd;  // Read taken
  wire logic wr_take = host_cs && host_wr;  // Write taken
  wire logic tx_win = host_addr >= 8'h20 && host_addr <= 8'h3c;  // Transmit aliases

  AST_READ_ANSWER: assert property (rd_take |=> host_rvalid)
    else $error("read not answered next cycle");
  AST_NO_STRAY_ANSWER: assert property (!rd_take |=> !host_rvalid)
    else $error("answer without read");
  AST_RXS_POP: assert property (rd_take && host_addr == 8'h40 |-> rxs_pop == rxs_valid)
    else $error("rx status pop wrong");
  AST_RXS_PEEK: assert property (rd_take && host_addr == 8'h44 && rxs_valid |->
    !rxs_pop ##1 host_rdata == $past(rxs_data))
    else $error("rx status peek wrong");
  AST_TXS_POP: assert property (rd_take && host_addr == 8'h48 |-> txs_pop == txs_valid)
    else $error("tx status pop wrong");
  AST_TXS_PEEK: assert property (rd_take && host_addr == 8'h4c |-> !txs_pop)
    else $error("tx status peek popped");
  AST_RXD_ALIAS: assert property (rd_take && host_addr <= 8'h1c
    && host_addr[1:0] == 2'b00 |-> rxd_pop == rxd_valid)
    else $error("rx data alias did not pop");
  AST_NO_STRAY_POP: assert property (!rd_take |-> !rxd_pop && !rxs_pop && !txs_pop)
    else $error("pop without read");
  AST_ENDIAN: assert property (rd_take && host_addr == 8'h64 |=>
    host_rdata == 32'h8765_4321)
    else $error("endian check value wrong");
  AST_TX_READ_ZERO: assert property (rd_take && tx_win |=> host_rdata == 32'h0000_0000)
    else $error("transmit alias read not zero");
  AST_TX_PUSH: assert property (wr_take && tx_win && !txd_valid |=>
    txd_valid && txd_data == $past(host_wdata))
    else $error("transmit write not pushed");
  AST_TX_HOLD: assert property (txd_valid && !txd_ready |=>
    txd_valid && $stable(txd_data))
    else $error("stalled word lost");
endmodule // hrm_map_monitor

bind hrm_map hrm_map_monitor i_hrm_map_monitor (.clk(clk), .reset_n(reset_n),
  .sw_reset_n(sw_reset_n), .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd),
  .host_addr(host_addr), .host_wdata(host_wdata), .host_rvalid(host_rvalid),
  .host_rdata(host_rdata), .rxd_valid(rxd_valid), .rxd_pop(rxd_pop),
  .rxs_valid(rxs_valid), .rxs_data(rxs_data), .rxs_pop(rxs_pop), .txs_valid(txs_valid),
  .txs_pop(txs_pop), .txd_valid(txd_valid), .txd_data(txd_data), .txd_ready(txd_ready),
  .txd_host_ready(txd_host_ready));

// *** tb/hrm_host_model.sv ***
// Host processor model for the register map strobes.
// Assumes one-cycle strobes and a registered one-cycle read answer.
`timescale 1ns/1ps
module hrm_host_model (
  input  wire logic               clk,
  output logic                    host_cs,
  output logic                    host_wr,
  output logic                    host_rd,
  output hrm_pkg::hrm_addr_t      host_addr,
  output hrm_pkg::hrm_word_t      host_wdata,
  input  wire logic               host_rvalid,
  input  wire hrm_pkg::hrm_word_t host_rdata
);
  // Idle bus at time zero
  initial
  begin
    {host_cs, host_wr, host_rd} = 3'h0;
    host_addr = 8'h00;
    host_wdata = 32'h0000_0000;
  end
  // One write; reserved places are never written, since that may upset the part
  task automatic wr(input hrm_pkg::hrm_addr_t a, input hrm_pkg::hrm_word_t d);
    if (a == 8'h60 || a == 8'h94 || a >= 8'hb8)
      return;
    @(posedge clk);
    #1;
    {host_cs, host_wr, host_addr, host_wdata} = {2'b11, a, d};
    @(posedge clk);
    #1;
    {host_cs, host_wr, host_addr, host_wdata} = {2'b00, ~a, ~d};
  endtask
  // One read; an absent answer comes back as unknown
  task automatic rd(input hrm_pkg::hrm_addr_t a, output hrm_pkg::hrm_word_t d);
    @(posedge clk);
    #1;
    {host_cs, host_rd, host_addr} = {2'b11, a};
    @(posedge clk);
    #1;
    {host_cs, host_rd, host_addr} = {2'b00, ~a};
    d = (host_rvalid === 1'b1) ? host_rdata : 32'hxxxx_xxxx;
  endtask
endmodule // hrm_host_model

// *** tb/hrm_map_tb.sv ***
// Self-checking bench for the host register map.
// Assumes the host model drives strobes; FIFO heads and sink live here.
`timescale 1ns/1ps
module hrm_map_tb;
  typedef hrm_pkg::hrm_word_t hrm_w_t;  // Host word
  localparam logic [15:0] PID = 16'h0c3d;  // Arbitrary value
  localparam logic [15:0] REV = 16'h0007;  // Arbitrary value
  logic clk = 1'b0, reset_n = 1'b0, sw_reset_n = 1'b1, txd_ready = 1'b0;
  logic host_cs, host_wr, host_rd, host_rvalid, rxd_pop, rxs_pop, txs_pop;
  logic rxd_valid = 1'b0, rxs_valid = 1'b0, txs_valid = 1'b0;
  logic txd_valid, txd_host_ready, soft_rst_req;
  logic [3:0] fifo_size_sel;
  hrm_pkg::hrm_addr_t host_addr;
  hrm_w_t host_wdata, host_rdata, txd_data, irq_cfg, int_en, rx_cfg, tx_cfg;
  hrm_w_t rxd_data = 32'h0, rxs_data = 32'h0, txs_data = 32'h0, int_events = 32'h0;
  hrm_w_t rxd_q[$], rxs_q[$], txs_q[$], sink_q[$];  // FIFO contents and drained words
  hrm_w_t d;
  int num_errors = 0;
  int checks_done = 0;

  // 40 MHz clock
  always #12.5 clk = ~clk;

  hrm_map #(.PART_ID(PID), .REVISION(REV)) i_hrm_map (.clk(clk), .reset_n(reset_n),
    .sw_reset_n(sw_reset_n), .host_cs(host_cs), .host_wr(host_wr), .host_rd(host_rd),
    .host_addr(host_addr), .host_wdata(host_wdata), .host_rvalid(host_rvalid),
    .host_rdata(host_rdata), .rxd_valid(rxd_valid), .rxd_data(rxd_data), .rxd_pop(rxd_pop),
    .rxs_valid(rxs_valid), .rxs_data(rxs_data), .rxs_pop(rxs_pop), .txs_valid(txs_valid),
    .txs_data(txs_data), .txs_pop(txs_pop), .txd_valid(txd_valid), .txd_data(txd_data),
    .txd_ready(txd_ready), .txd_host_ready(txd_host_ready), .int_events(int_events),
    .rx_fifo_level(32'h0), .tx_fifo_level(32'h0000_1200), .timer_count(32'h0000_ffff),
    .rx_drop_inc(1'b0), .fifo_size_sel(fifo_size_sel), .soft_reset_req(soft_rst_req),
    .irq_pin_config(irq_cfg), .interrupt_enable(int_en), .receive_config(rx_cfg),
    .transmit_config(tx_cfg));

  hrm_host_model i_hrm_host_model (.clk(clk), .host_cs(host_cs), .host_wr(host_wr),
    .host_rd(host_rd), .host_addr(host_addr), .host_wdata(host_wdata),
    .host_rvalid(host_rvalid), .host_rdata(host_rdata));

  // FIFO heads: pops land on the edge, heads refresh just after
  always @(posedge clk)
  begin
    if (rxd_pop) void'(rxd_q.pop_front());
    if (rxs_pop) void'(rxs_q.pop_front());
    if (txs_pop) void'(txs_q.pop_front());
    if (txd_valid && txd_ready) sink_q.push_back(txd_data);
    #1;
    // Empty heads toggle so stale data never looks valid
    {rxd_valid, rxs_valid, txs_valid} = {rxd_q.size() > 0, rxs_q.size() > 0, txs_q.size() > 0};
    rxd_data = rxd_valid ? rxd_q[0] : ~rxd_data;
    rxs_data = rxs_valid ? rxs_q[0] : ~rxs_data;
    txs_data = txs_valid ? txs_q[0] : ~txs_data;
  end

  // Compare and count
  task automatic chk(input string n, input hrm_w_t e, input hrm_w_t g);
    checks_done++;
    if (g !== e)
    begin
      $display("MISMATCH %s expected %h seen %h", n, e, g);
      num_errors++;
    end
  endtask
  // Read one place and compare
  task automatic rc(input hrm_pkg::hrm_addr_t a, input hrm_w_t e);
    i_hrm_host_model.rd(a, d);
    chk($sformatf("read %h", a), e, d);
  endtask

  // Every decoded register but the free-running counter after system reset
  task automatic t_defaults();
    hrm_w_t e;
    for (int a = 8'h50; a <= 8'hb4; a += 4)
    begin
      case (a)
        8'h50: e = {PID, REV};
        8'h64: e = 32'h8765_4321;
        8'h68: e = 32'h4800_0000;
        8'h74: e = 32'h0005_0000;
        8'h80: e = 32'h0000_1200;
        8'h8c, 8'h90: e = 32'h0000_ffff;
        default: e = 32'h0000_0000;
      endcase
      // Reserved places are skipped; the free-running counter has no fixed value
      if (a != 8'h60 && a != 8'h94 && a != 8'h9c)
        rc(8'(a), e);
    end
  endtask
  // Writes to read-only places change nothing
  task automatic t_readonly();
    i_hrm_host_model.wr(8'h50, 32'h0);
    i_hrm_host_model.wr(8'h64, 32'h0);
    rc(8'h50, {PID, REV});
    rc(8'h64, 32'h8765_4321);
    rc(8'h2c, 32'h0);
  endtask
  // Status port: peek keeps the head, pop removes it, empty stays sane
  task automatic t_status(input hrm_pkg::hrm_addr_t pa, input hrm_pkg::hrm_addr_t ka,
    ref hrm_w_t q[$]);
    q.push_back({24'h1111_00, pa});
    q.push_back({24'h2222_00, pa});
    repeat (2) @(posedge clk);
    rc(ka, {24'h1111_00, pa});
    rc(ka, {24'h1111_00, pa});
    rc(pa, {24'h1111_00, pa});
    rc(ka, {24'h2222_00, pa});
    rc(pa, {24'h2222_00, pa});
    rc(pa, 32'h0);
    chk("status fill", 32'h0, 32'(q.size()));
  endtask
  // Every receive alias drains the one FIFO in order
  task automatic t_rx_data();
    for (int i = 0; i < 8; i++)
      rxd_q.push_back(32'hcafe_0000 + 32'(i));
    repeat (2) @(posedge clk);
    for (int i = 0; i < 8; i++)
      rc(8'(4 * i), 32'hcafe_0000 + 32'(i));
    chk("rx fill", 32'h0, 32'(rxd_q.size()));
  endtask
  // Transmit aliases feed one stream; full buffer refuses a third word
  task automatic t_tx_data();
    for (int i = 0; i < 8; i++)
    begin
      if (i == 3)
        txd_ready = 1'b1;
      i_hrm_host_model.wr(8'h20 + 8'(4 * i), 32'h0000_d000 + 32'(i));
      if (i == 1)
        chk("host ready", 32'h0, 32'(txd_host_ready));
    end
    repeat (4) @(posedge clk);
    chk("tx count", 32'd7, 32'(sink_q.size()));
    for (int k = 0; k < 7 && k < sink_q.size(); k++)
      chk("tx word", 32'h0000_d000 + 32'(k < 2 ? k : k + 1), sink_q[k]);
  endtask
  // Write one clears, write zero keeps
  task automatic t_w1c();
    @(posedge clk);
    #1;
    int_events = 32'h0000_0005;
    @(posedge clk);
    #1;
    int_events = 32'h0;
    rc(8'h58, 32'h0000_0005);
    i_hrm_host_model.wr(8'h58, 32'h0000_0004);
    i_hrm_host_model.wr(8'h58, 32'h0000_0000);
    rc(8'h58, 32'h0000_0001);
  endtask
  // Software reset spares the exempt pin config bits and clears the config outputs; sizes follow hardware config
  task automatic t_swreset();
    i_hrm_host_model.wr(8'h54, 32'hff00_0111);
    i_hrm_host_model.wr(8'h5c, 32'h0000_00ff);
    i_hrm_host_model.wr(8'h74, 32'h000a_0001);
    chk("reset request", 32'h1, 32'(soft_rst_req));
    chk("size select", 32'ha, 32'(fifo_size_sel));
    chk("irq config", 32'hff00_0111, irq_cfg);
    i_hrm_host_model.wr(8'h6c, 32'h0000_0100);
    i_hrm_host_model.wr(8'h70, 32'h0000_0002);
    chk("request cleared", 32'h0, 32'(soft_rst_req));
    chk("cfg outputs", 32'h0000_01ff, int_en | rx_cfg | tx_cfg);
    @(posedge clk);
    #1;
    sw_reset_n = 1'b0;
    @(posedge clk);
    #1;
    sw_reset_n = 1'b1;
    rc(8'h54, 32'h0000_0011);
    rc(8'h5c, 32'h0);
    chk("size default", 32'h5, 32'(fifo_size_sel));
    chk("cfg defaults", 32'h0, int_en | rx_cfg | tx_cfg);
  endtask

  // Counts, verdict, end of run
  task automatic summarize();
    $display("checks %0d errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0)
      $display("== PASSED ==");
    else
      $display("== FAILED ==");
    $finish;
  endtask

  // Watchdog: tests need about 150 cycles, allow far more
  initial
  begin
    #(25 * 5000);
    num_errors++;
    $display("watchdog expired");
    summarize();
  end

  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk);
    #1;
    reset_n = 1'b1;
    t_defaults();
    t_readonly();
    t_status(8'h40, 8'h44, rxs_q);
    t_status(8'h48, 8'h4c, txs_q);
    t_rx_data();
    t_tx_data();
    t_w1c();
    t_swreset();
    summarize();
  end
endmodule // hrm_map_tb
